// ==== octal_adc_readout_pkg.sv ====
// constants for the octal converter serial readout block
package octal_adc_readout_pkg;

    // channel and word shape
    localparam int NUM_CH = 8;
    localparam int WORD_BITS = 13;
    localparam int NUM_LANES = 4;
    localparam int LANE_CH = 2;
    localparam int STREAM_BITS = NUM_CH * WORD_BITS;
    localparam int IDX_W = 8;

    // register bus shape
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    // register offsets
    localparam logic [3:0] OFS_STATUS = 4'h0;
    localparam logic [3:0] OFS_CONV_COUNT = 4'h1;
    localparam logic [3:0] OFS_CTRL = 4'h2;
    localparam logic [3:0] OFS_TEST_PATTERN = 4'h3;
    localparam logic [3:0] OFS_RESULT_BASE = 4'h8;

    // status field positions
    localparam int ST_REF_BUF_ON = 0;
    localparam int ST_ECHO_DISABLED = 1;
    localparam int ST_DOUBLE_EDGE = 2;
    localparam int ST_LVDS = 3;
    localparam int ST_LOW_POWER = 4;
    localparam int ST_ACQUIRING = 5;
    localparam int ST_BUSY = 6;

    // control field positions
    localparam int CTRL_PATTERN_EN = 0;

    // reset values
    localparam logic CTRL_RESET = 1'b0;
    localparam logic [12:0] TEST_PATTERN_RESET = 13'h0000;
    localparam logic [15:0] CONV_COUNT_RESET = 16'h0000;

    // timing: conversion phase length and system clock
    localparam int CONV_TIME_NS = 500;
    localparam int SYS_CLK_PERIOD_NS = 100;
    localparam int CONV_CYCLES = (CONV_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

    // output standard selected by the io strap
    typedef enum logic [1:0]
    {
        IO_CMOS = 2'b00,
        IO_LVDS = 2'b01,
        IO_LVDS_LOW_POWER = 2'b11
    } io_mode_e;

endpackage : octal_adc_readout_pkg

// ==== octal_adc_serial_readout.sv ====
// octal converter readout: conversion trigger, straps, serial shift-out on the shift clock
`timescale 1ns/1ps
`default_nettype none

module octal_adc_serial_readout
#(
    parameter int CONV_CYCLES = octal_adc_readout_pkg::CONV_CYCLES
)
(
    // system clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // register port
    input wire logic [octal_adc_readout_pkg::ADDR_W-1:0] regAddr,
    input wire logic [octal_adc_readout_pkg::DATA_W-1:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [octal_adc_readout_pkg::DATA_W-1:0] regReadData,
    // sampled values from the converter cores, system domain
    input wire logic [octal_adc_readout_pkg::NUM_CH*octal_adc_readout_pkg::WORD_BITS-1:0] sampleIn,
    // host link
    input wire logic convert_strobe_n,
    input wire logic shiftClock,
    // straps
    input wire logic rate_edge_select,
    input wire logic echo_clock_disable,
    input wire logic ioStrapLevel,
    input wire logic ioStrapFloating,
    input wire logic ref_buffer_enable,
    input wire logic refBufferEnableDriven,
    // converter control
    output logic acquiring,
    output logic convertBusy,
    output logic [3:0] refBufferOn,
    // cmos serial outputs
    output logic serialOutCh1,
    output logic serialOutCh2,
    output logic serialOutCh3,
    output logic serialOutCh4,
    output logic serialOutCh5,
    output logic serialOutCh6,
    output logic serialOutCh7,
    output logic serialOutCh8,
    // lvds lanes, single ended view of each pair
    output logic lvdsLaneA,
    output logic lvdsLaneB,
    output logic lvdsLaneC,
    output logic lvdsLaneD,
    // echoed shift clock
    output logic echoed_shift_clock
);

    localparam int NCH = octal_adc_readout_pkg::NUM_CH;
    localparam int WB = octal_adc_readout_pkg::WORD_BITS;
    localparam int IW = octal_adc_readout_pkg::IDX_W;
    // edges the strap synchronisers need to refill after reset
    localparam logic [1:0] STRAP_SETTLE = 2'h2;

    // synchroniser stages and captured straps
    logic cnvMeta_reg;
    logic cnvSync_reg;
    logic cnvPrev_reg;
    logic [4:0] strapMeta_reg;
    logic [4:0] strapSync_reg;
    logic strapsTaken_reg;
    logic doubleEdge_reg;
    logic echoDisabled_reg;
    logic refBufOn_reg;
    octal_adc_readout_pkg::io_mode_e ioMode_reg;
    logic [1:0] strapWait_reg;
    logic rateMeta_reg;
    logic rateSync_reg;

    // conversion state
    logic [NCH*WB-1:0] resultWord_reg;
    logic [15:0] convCount_reg;
    logic [15:0] busyCnt_reg;
    logic busy_reg;
    logic patternEn_reg;
    logic [WB-1:0] testPattern_reg;
    logic cnvFall;

    // link domain edge counters
    logic [IW-1:0] negCnt_reg;
    logic [IW-1:0] posCnt_reg;
    logic [IW-1:0] shiftIdx;
    logic [NCH-1:0] cmosBit;
    logic [3:0] laneBit;

    // convert strobe crosses into the system domain through two flops
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            cnvMeta_reg <= 1'b1;
            cnvSync_reg <= 1'b1;
            cnvPrev_reg <= 1'b1;
        end
        else
        begin
            cnvMeta_reg <= convert_strobe_n;
            cnvSync_reg <= cnvMeta_reg;
            cnvPrev_reg <= cnvSync_reg;
        end
    end

    // trigger path looks only at the strobe, never at the io mode
    assign cnvFall = cnvPrev_reg & ~cnvSync_reg;

    // straps are synchronised and taken once, three edges after reset release
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            strapMeta_reg <= 5'h00;
            strapSync_reg <= 5'h00;
        end
        else
        begin
            strapMeta_reg <= {refBufferEnableDriven, ref_buffer_enable, ioStrapFloating, ioStrapLevel,
                              echo_clock_disable};
            strapSync_reg <= strapMeta_reg;
        end
    end

    // strap decode waits until both synchroniser stages hold pin values, else it would take reset values
    // held static so the link domain may read it without its own edges
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            strapWait_reg <= 2'h0;
            strapsTaken_reg <= 1'b0;
            doubleEdge_reg <= 1'b0;
            echoDisabled_reg <= 1'b1;
            refBufOn_reg <= 1'b1;
            ioMode_reg <= octal_adc_readout_pkg::IO_CMOS;
        end
        else if (!strapsTaken_reg && strapWait_reg != STRAP_SETTLE)
            strapWait_reg <= strapWait_reg + 2'h1;
        else if (!strapsTaken_reg)
        begin
            strapsTaken_reg <= 1'b1;
            doubleEdge_reg <= rateSync_reg;
            echoDisabled_reg <= strapSync_reg[0];
            // undriven enable pin reads as high through its pull-up
            refBufOn_reg <= ~strapSync_reg[4] | strapSync_reg[3];
            if (strapSync_reg[2])
                ioMode_reg <= octal_adc_readout_pkg::IO_LVDS_LOW_POWER;
            else if (strapSync_reg[1])
                ioMode_reg <= octal_adc_readout_pkg::IO_LVDS;
            else
                ioMode_reg <= octal_adc_readout_pkg::IO_CMOS;
        end
    end

    // rate strap gets its own two-flop synchroniser
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            rateMeta_reg <= 1'b0;
            rateSync_reg <= 1'b0;
        end
        else
        begin
            rateMeta_reg <= rate_edge_select;
            rateSync_reg <= rateMeta_reg;
        end
    end

    // results captured at the start of conversion; test pattern replaces every channel
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            resultWord_reg <= '0;
        else if (cnvFall)
        begin
            for (int ch = 0; ch < NCH; ch++)
                resultWord_reg[ch*WB +: WB] <= patternEn_reg ? testPattern_reg
                                                             : sampleIn[ch*WB +: WB];
        end
    end

    // conversion phase timer and conversion counter
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            busy_reg <= 1'b0;
            busyCnt_reg <= 16'h0000;
            convCount_reg <= octal_adc_readout_pkg::CONV_COUNT_RESET;
        end
        else if (cnvFall)
        begin
            busy_reg <= 1'b1;
            busyCnt_reg <= 16'(CONV_CYCLES);
            convCount_reg <= convCount_reg + 16'h0001;
        end
        else if (busy_reg)
        begin
            busyCnt_reg <= busyCnt_reg - 16'h0001;
            busy_reg <= (busyCnt_reg != 16'h0001);
        end
    end

    // acquisition holds whenever the strobe is high and no conversion runs
    assign acquiring = cnvSync_reg & ~busy_reg;
    assign convertBusy = busy_reg;
    assign refBufferOn = {4{refBufOn_reg}};

    // register writes
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            patternEn_reg <= octal_adc_readout_pkg::CTRL_RESET;
            testPattern_reg <= octal_adc_readout_pkg::TEST_PATTERN_RESET;
        end
        else if (regWrite)
        begin
            if (regAddr == octal_adc_readout_pkg::OFS_CTRL)
                patternEn_reg <= regWriteData[octal_adc_readout_pkg::CTRL_PATTERN_EN];
            if (regAddr == octal_adc_readout_pkg::OFS_TEST_PATTERN)
                testPattern_reg <= regWriteData[WB-1:0];
        end
    end

    // register reads, data stands in the following cycle only; unmapped reads zero
    always_ff @(posedge sys_clk)
    begin
        if (srst || !regRead)
            regReadData <= '0;
        else
        begin
            regReadData <= '0;
            unique case (regAddr)
                octal_adc_readout_pkg::OFS_STATUS:
                begin
                    regReadData[octal_adc_readout_pkg::ST_REF_BUF_ON] <= refBufOn_reg;
                    regReadData[octal_adc_readout_pkg::ST_ECHO_DISABLED] <= echoDisabled_reg;
                    regReadData[octal_adc_readout_pkg::ST_DOUBLE_EDGE] <= doubleEdge_reg;
                    regReadData[octal_adc_readout_pkg::ST_LVDS] <= ioMode_reg[0];
                    regReadData[octal_adc_readout_pkg::ST_LOW_POWER] <= ioMode_reg[1];
                    regReadData[octal_adc_readout_pkg::ST_ACQUIRING] <= acquiring;
                    regReadData[octal_adc_readout_pkg::ST_BUSY] <= busy_reg;
                end
                octal_adc_readout_pkg::OFS_CONV_COUNT:
                    regReadData <= convCount_reg;
                octal_adc_readout_pkg::OFS_CTRL:
                    regReadData[octal_adc_readout_pkg::CTRL_PATTERN_EN] <= patternEn_reg;
                octal_adc_readout_pkg::OFS_TEST_PATTERN:
                    regReadData[WB-1:0] <= testPattern_reg;
                default:
                begin
                    if (regAddr[3])
                        regReadData[WB-1:0] <= resultWord_reg[regAddr[2:0]*WB +: WB];
                end
            endcase
        end
    end

    // falling-edge counter; the high strobe clears it, since the shift clock stands still between frames
    always_ff @(negedge shiftClock or posedge convert_strobe_n)
    begin
        if (convert_strobe_n)
            negCnt_reg <= '0;
        else if (shiftIdx < IW'(octal_adc_readout_pkg::STREAM_BITS))
            negCnt_reg <= negCnt_reg + IW'(1);
    end

    // rising-edge counter, used in double-edge mode only
    always_ff @(posedge shiftClock or posedge convert_strobe_n)
    begin
        if (convert_strobe_n)
            posCnt_reg <= '0;
        else if (doubleEdge_reg && shiftIdx < IW'(octal_adc_readout_pkg::STREAM_BITS))
            posCnt_reg <= posCnt_reg + IW'(1);
    end

    // one shared index moves every output together
    assign shiftIdx = negCnt_reg + posCnt_reg;

    // bit at a given stream position, starting from a given channel, msb first
    function automatic logic streamBit(input logic [NCH*WB-1:0] words, input int base, input logic [IW-1:0] idx);
        int word;
        int bitPos;
        int ch;
        word = int'(idx) / WB;
        bitPos = int'(idx) % WB;
        ch = (base + word) % NCH;
        if (int'(idx) >= octal_adc_readout_pkg::STREAM_BITS)
            return 1'b0;
        return words[ch*WB + (WB - 1 - bitPos)];
    endfunction : streamBit

    // index zero shows the sign bit before any edge arrives
    always_comb
    begin
        for (int k = 0; k < NCH; k++)
            cmosBit[k] = (ioMode_reg == octal_adc_readout_pkg::IO_CMOS)
                         & streamBit(resultWord_reg, k, shiftIdx);
        for (int p = 0; p < octal_adc_readout_pkg::NUM_LANES; p++)
            laneBit[p] = (ioMode_reg != octal_adc_readout_pkg::IO_CMOS)
                         & streamBit(resultWord_reg, p * octal_adc_readout_pkg::LANE_CH, shiftIdx);
    end

    // pins
    assign serialOutCh1 = cmosBit[0];
    assign serialOutCh2 = cmosBit[1];
    assign serialOutCh3 = cmosBit[2];
    assign serialOutCh4 = cmosBit[3];
    assign serialOutCh5 = cmosBit[4];
    assign serialOutCh6 = cmosBit[5];
    assign serialOutCh7 = cmosBit[6];
    assign serialOutCh8 = cmosBit[7];
    assign lvdsLaneA = laneBit[0];
    assign lvdsLaneB = laneBit[1];
    assign lvdsLaneC = laneBit[2];
    assign lvdsLaneD = laneBit[3];

    // echo is a gated copy of the shift clock; gating avoids toggling when nobody listens
    assign echoed_shift_clock = shiftClock & ~echoDisabled_reg;

endmodule : octal_adc_serial_readout

`default_nettype wire

// ==== octal_adc_readout_monitor.sv ====
// assertion checker for the octal converter readout ports
`timescale 1ns/1ps
`default_nettype none
module octal_adc_readout_monitor
#(
    parameter int CONV_CYCLES = 2
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // watched ports
    input wire logic convert_strobe_n,
    input wire logic shiftClock,
    input wire logic acquiring,
    input wire logic convertBusy,
    input wire logic [3:0] refBufferOn,
    input wire logic serialOutCh1,
    input wire logic lvdsLaneA,
    input wire logic echoed_shift_clock
);
    int busyCnt;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    // length of the current busy stretch; catches a timer that never expires
    always_ff @(posedge sys_clk)
    begin
        if (srst || !convertBusy)
            busyCnt <= 0;
        else
            busyCnt <= busyCnt + 1;
    end

    AST_ACQ_EXCLUSIVE: assert property (convertBusy |-> !acquiring)
        else $error("acquiring while converting");
    AST_ACQ_HELD: assert property (convert_strobe_n [*3] ##0 !convertBusy |-> acquiring)
        else $error("strobe high but not acquiring");
    AST_BUSY_FOLLOWS_FALL: assert property ($fell(convert_strobe_n) |-> ##[1:4] convertBusy)
        else $error("no conversion after strobe fall");
    AST_BUSY_BOUND: assert property (convertBusy |-> busyCnt < CONV_CYCLES)
        else $error("conversion phase too long");
    AST_BUSY_START: assert property ($rose(convertBusy) |-> !convert_strobe_n)
        else $error("conversion without strobe low");
    AST_ECHO_GATED: assert property (echoed_shift_clock |-> shiftClock)
        else $error("echoed clock without shift clock");
    AST_REF_ALL_SAME: assert property (refBufferOn == 4'h0 || refBufferOn == 4'hF)
        else $error("reference buffers differ");
    AST_MODE_EXCL: assert property (serialOutCh1 |-> !lvdsLaneA)
        else $error("cmos and lvds outputs both active");

    // main scenarios reached
    cover property ($rose(convertBusy));
    cover property (echoed_shift_clock);
    cover property (lvdsLaneA);
endmodule : octal_adc_readout_monitor

bind octal_adc_serial_readout octal_adc_readout_monitor #(.CONV_CYCLES(CONV_CYCLES)) mon
(
    .sys_clk(sys_clk), .srst(srst), .convert_strobe_n(convert_strobe_n), .shiftClock(shiftClock),
    .acquiring(acquiring), .convertBusy(convertBusy), .refBufferOn(refBufferOn),
    .serialOutCh1(serialOutCh1), .lvdsLaneA(lvdsLaneA), .echoed_shift_clock(echoed_shift_clock)
);
`default_nettype wire

// ==== host_link_model.sv ====
// host side model: drives convert strobe and shift clock
`timescale 1ns/1ps
`default_nettype none
module host_link_model
(
    // host link pins
    output logic convStrobeN,
    output logic shiftClock
);
    // idle: acquiring, clock parked low between frames
    initial
    begin
        convStrobeN = 1'b1;
        shiftClock = 1'b0;
    end
    // falling strobe starts a conversion; sync and conversion are waited out first
    task automatic start_conv();
        #3 convStrobeN = 1'b0;
        #1200;
    endtask : start_conv
    // one shift edge, then half of a 15 ns period so outputs settle before the next edge
    task automatic edge_clk();
        shiftClock = ~shiftClock;
        #7.5;
    endtask : edge_clk
    // clock already low; strobe high ends the frame and clears the link index
    task automatic end_frame();
        #5 convStrobeN = 1'b1;
        #200;
    endtask : end_frame
endmodule : host_link_model
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the octal converter readout
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic sys_clk;
    logic srst;
    logic [3:0] regAddr;
    logic [15:0] regWriteData;
    logic regWrite;
    logic regRead;
    logic [15:0] regReadData;
    logic [103:0] sampleIn;
    logic rateSel, echoDis, ioLevel, ioFloat, refEn, refDriven;
    logic convStrobeN, shiftClock, acquiring, convertBusy, echoClk;
    logic [3:0] refOn;
    logic [7:0] sout;
    logic [3:0] lane;
    logic [12:0] words [8];
    int fails = 0;
    int checks = 0;
    int cycles = 0;

    host_link_model host (.convStrobeN(convStrobeN), .shiftClock(shiftClock));
    octal_adc_serial_readout #(.CONV_CYCLES(2)) DUT
    (
        .sys_clk(sys_clk), .srst(srst), .regAddr(regAddr), .regWriteData(regWriteData),
        .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData), .sampleIn(sampleIn),
        .convert_strobe_n(convStrobeN), .shiftClock(shiftClock), .rate_edge_select(rateSel),
        .echo_clock_disable(echoDis), .ioStrapLevel(ioLevel), .ioStrapFloating(ioFloat),
        .ref_buffer_enable(refEn), .refBufferEnableDriven(refDriven), .acquiring(acquiring),
        .convertBusy(convertBusy), .refBufferOn(refOn), .serialOutCh1(sout[0]), .serialOutCh2(sout[1]),
        .serialOutCh3(sout[2]), .serialOutCh4(sout[3]), .serialOutCh5(sout[4]), .serialOutCh6(sout[5]),
        .serialOutCh7(sout[6]), .serialOutCh8(sout[7]), .lvdsLaneA(lane[0]), .lvdsLaneB(lane[1]),
        .lvdsLaneC(lane[2]), .lvdsLaneD(lane[3]), .echoed_shift_clock(echoClk)
    );

    // 10 MHz system clock
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // hang guard; the whole run needs well under a thousand cycles
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            fails++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (fails == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // straps must be steady before release, they are latched just after it
    task automatic reset_with(input logic [5:0] s);
        @(posedge sys_clk);
        srst <= 1'b1;
        {rateSel, echoDis, ioLevel, ioFloat, refEn, refDriven} <= s;
        repeat (16) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask : reset_with

    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWriteData <= d;
        regWrite <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask : reg_wr

    // read data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge sys_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1;
        check("regReadData", regReadData, e);
    endtask : reg_rd

    function automatic logic bit_at(input int ch, input int i);
        logic [12:0] w;
        // past the last of the eight words the outputs rest low
        if (i >= 104)
            return 1'b0;
        w = words[(ch + i / 13) % 8];
        return w[12 - i % 13];
    endfunction : bit_at

    // convert, then check every serial output, lvds lane and the echoed clock after each shift edge
    task automatic frame(input int edges, input logic lv);
        int e;
        int i;
        int k;
        @(posedge sys_clk);
        host.start_conv();
        check("acquiring", acquiring, 16'h0000);
        check("convertBusy", convertBusy, 16'h0000);
        for (e = 0; e <= edges; e++)
        begin
            if (e > 0)
                host.edge_clk();
            i = rateSel ? e : e / 2;
            for (k = 0; k < 8; k++)
                check("serialOut", sout[k], lv ? 1'b0 : bit_at(k, i));
            for (k = 0; k < 4; k++)
                check("lvdsLane", lane[k], lv ? bit_at(2 * k, i) : 1'b0);
            check("echo", echoClk, shiftClock & ~echoDis);
        end
        host.end_frame();
        @(posedge sys_clk);
        #1;
        check("acquiring", acquiring, 16'h0001);
    endtask : frame

    task automatic cmos_sdr_readout();
        int k;
        reset_with(6'b000001);
        check("refBufferOn", refOn, 4'h0);
        reg_rd(4'h0, 16'h0020);
        reg_rd(4'h5, 16'h0000);
        for (k = 0; k < 8; k++)
            words[k] = sampleIn[k * 13 +: 13];
        frame(208, 1'b0);
        reg_rd(4'h1, 16'h0001);
        reg_wr(4'h1, 16'h00FF);
        reg_rd(4'h1, 16'h0001);
        reg_rd(4'hA, {3'h0, words[2]});
    endtask : cmos_sdr_readout

    task automatic lvds_ddr_readout();
        reset_with(6'b110100);
        check("refBufferOn", refOn, 4'hF);
        reg_rd(4'h0, 16'h003F);
        frame(52, 1'b1);
    endtask : lvds_ddr_readout

    task automatic lvds_sdr_pattern();
        int k;
        reset_with(6'b001011);
        check("refBufferOn", refOn, 4'hF);
        reg_rd(4'h0, 16'h0029);
        reg_wr(4'h3, 16'h1B6D);
        reg_wr(4'h2, 16'h0001);
        reg_rd(4'h3, 16'h1B6D);
        for (k = 0; k < 8; k++)
            words[k] = 13'h1B6D;
        frame(60, 1'b1);
    endtask : lvds_sdr_pattern

    // main sequence
    initial
    begin
        int k;
        srst = 1'b1;
        regAddr = 4'h0;
        regWriteData = 16'h0000;
        regWrite = 1'b0;
        regRead = 1'b0;
        {rateSel, echoDis, ioLevel, ioFloat, refEn, refDriven} = 6'h00;
        for (k = 0; k < 8; k++)
            sampleIn[k * 13 +: 13] = 13'h1A5C + 13'h0397 * 13'(k);
        cmos_sdr_readout();
        lvds_ddr_readout();
        lvds_sdr_pattern();
        end_sim();
    end
endmodule : testbench
`default_nettype wire
